// *** dv/dct_host_model.sv ***
// Purpose: Host channel clock source
// Assumes: 400 ns channel period
// Notes: Clock rests low while clkRun is low, as in deep sleep
`timescale 1ns/1ps
`default_nettype none
module dct_host_model (
  // Control
  input wire logic clkRun,
  // Channel clock
  output logic chanClk
);
  // No bank, refresh or calibration packets leave this model, so the
  // spacings and intervals owed for them hold without any tracking
  // Half period toggle; bench drops clkRun only in deep sleep, after entry, and raises it before wake
  initial
  begin
    chanClk = 1'b0;
    forever
    begin
      #200;
      chanClk = clkRun ? ~chanClk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** dv/dct_power_assertions.sv ***
// Purpose: Port-level checks on the power and framing block
// Assumes: Bench builds the block with DWAKE_B_CH 20, DWAKE_A_CYC 4
// Notes: Bounds include two cycles of input sync
`timescale 1ns/1ps
`default_nettype none
module dct_power_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Requests
  input wire logic idleReq,
  input wire logic lightSleepReq,
  input wire logic deepSleepReq,
  input wire logic wakeReq,
  input wire logic rowValid,
  // Results
  input wire logic colSlotValid,
  input wire logic [2:0] powerState,
  input wire logic listenActive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_idle_in; powerState == 3'h0 && $rose(idleReq) |-> ##[1:5] powerState == 3'h1; endproperty
  a_idle_in: assert property (p_idle_in) else $error("idle entry late");
  property p_idle_out; powerState == 3'h1 && $fell(idleReq) |-> ##[1:5] powerState == 3'h0; endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle exit late");
  property p_lsl_in; powerState == 3'h0 && $rose(lightSleepReq) |-> ##[3:80] powerState == 3'h2; endproperty
  a_lsl_in: assert property (p_lsl_in) else $error("light sleep entry late");
  property p_dsl_in; powerState == 3'h0 && $rose(deepSleepReq) |-> ##[3:80] powerState == 3'h3; endproperty
  a_dsl_in: assert property (p_dsl_in) else $error("deep sleep entry late");
  property p_lsl_out; powerState == 3'h2 && $rose(wakeReq) |-> ##[1:8] powerState == 3'h0; endproperty
  a_lsl_out: assert property (p_lsl_out) else $error("light wake late");
  property p_dsl_out; powerState == 3'h3 && $rose(wakeReq) |-> ##[100:250] powerState == 3'h0; endproperty
  a_dsl_out: assert property (p_dsl_out) else $error("deep wake off");
  property p_frame; powerState == 3'h0 && $rose(rowValid) |-> ##[50:75] colSlotValid; endproperty
  a_frame: assert property (p_frame) else $error("column slot off");
  property p_pulse; colSlotValid |=> !colSlotValid; endproperty
  a_pulse: assert property (p_pulse) else $error("slot pulse too long");
  property p_listen; listenActive == (powerState == 3'h0); endproperty
  a_listen: assert property (p_listen) else $error("listen flag wrong");
  c_slot: cover property (colSlotValid);
  c_deep: cover property (powerState == 3'h3);
  c_exitb: cover property (powerState == 3'h6);
endmodule
bind dct_power dct_power_assertions dct_power_assertions_i (.ref_clk(ref_clk), .rst(rst), .idleReq(idleReq),
  .lightSleepReq(lightSleepReq), .deepSleepReq(deepSleepReq), .wakeReq(wakeReq), .rowValid(rowValid),
  .colSlotValid(colSlotValid), .powerState(powerState), .listenActive(listenActive));
`default_nettype wire

// *** dv/dct_power_tb.sv ***
// Purpose: Self-checking bench for the power and framing block
// Assumes: Shortened deep-wake counts
// Notes: Inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
`include "dct_defines.vh"
module dct_power_tb;
  logic ref_clk, rst, chanClk, clkRun, idleReq, lightSleepReq, deepSleepReq, wakeReq;
  logic rowValid, rowReady, colSlotValid, listenActive;
  logic [7:0] rowData, colSlotData;
  logic [2:0] powerState;
  logic [7:0] seen[$];
  int err_total, check_count;
  dct_power #(.DWAKE_B_CH(20), .DWAKE_A_CYC(4)) dct_power_i (.ref_clk(ref_clk), .rst(rst), .chanClk(chanClk),
    .idleReq(idleReq), .lightSleepReq(lightSleepReq), .deepSleepReq(deepSleepReq), .wakeReq(wakeReq),
    .rowValid(rowValid), .rowData(rowData), .rowReady(rowReady), .colSlotValid(colSlotValid),
    .colSlotData(colSlotData), .powerState(powerState), .listenActive(listenActive));
  dct_host_model dct_host_model_i (.clkRun(clkRun), .chanClk(chanClk));
  // Reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Slot pulses stand one cycle, so the falling edge sees each once
  always @(negedge ref_clk)
    if (colSlotValid === 1'b1) seen.push_back(colSlotData);
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait for a power state
  task automatic wait_state(input logic [2:0] s, input int lim);
    while (powerState !== s && lim > 0)
    begin
      tick(1);
      lim--;
    end
    cmp(powerState, s);
  endtask
  // Row held past one channel edge; data scrambled once released
  task automatic send_row(input logic [7:0] d);
    rowData = d;
    rowValid = 1'b1;
    tick(12);
    rowValid = 1'b0;
    rowData = ~d;
    tick(12);
  endtask
  task automatic frames;
    seen.delete();
    send_row(8'h3C);
    send_row(8'hC3);
    cmp(rowReady, 1'b1);
    tick(90);
    cmp(8'(seen.size()), 8'h02);
    cmp(seen[0], 8'h3C);
    cmp(seen[1], 8'hC3);
  endtask
  task automatic idle_cycle;
    seen.delete();
    idleReq = 1'b1;
    wait_state(`DCT_ST_IDLE, 8);
    cmp(listenActive, 1'b0);
    send_row(8'h5A);
    idleReq = 1'b0;
    wait_state(`DCT_ST_ACTIVE, 8);
    cmp(listenActive, 1'b1);
    tick(70);
    cmp(8'(seen.size()), 8'h00);
  endtask
  // Lanes stay quiet from entry until wake
  task automatic sleep_wake(input logic deep);
    lightSleepReq = ~deep;
    deepSleepReq = deep;
    wait_state(`DCT_ST_ENTER, 6);
    wait_state(deep ? `DCT_ST_DSLEEP : `DCT_ST_LSLEEP, 70);
    lightSleepReq = 1'b0;
    deepSleepReq = 1'b0;
    // Light sleep is woken well inside its time limit with the clock left running;
    // deep sleep keeps the clock 100 channel cycles, then stops and restarts it
    tick(deep ? 800 : 60);
    if (deep)
    begin
      clkRun = 1'b0;
      tick(40);
      clkRun = 1'b1;
      tick(16);
    end
    wakeReq = 1'b1;
    wait_state(`DCT_ST_EXITB, deep ? 20 : 6);
    wait_state(`DCT_ST_ACTIVE, deep ? 180 : 4);
    wakeReq = 1'b0;
    tick(4);
  endtask
  // Watchdog
  initial
  begin
    tick(10000);
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    clkRun = 1'b1;
    {idleReq, lightSleepReq, deepSleepReq, wakeReq, rowValid} = 5'h00;
    rowData = 8'h00;
    tick(3);
    rst = 1'b0;
    tick(4);
    frames();
    idle_cycle();
    sleep_wake(1'b0);
    sleep_wake(1'b1);
    frames();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** hw/dct_defines.vh ***
// Purpose: Constants for the device-side channel power and timing block
// Assumes: Reference clock 20 MHz (50 ns); channel clock sampled as a plain input
// Notes: Times kept in printed units; cycle counts derived from them
`ifndef DCT_DEFINES_VH
`define DCT_DEFINES_VH
`define DCT_REF_PERIOD_NS 50
`define DCT_LWAKE_A_NS 50
`define DCT_LWAKE_B_NS 40
`define DCT_DWAKE_A_US 4
`define DCT_DWAKE_B_CH 9000
`define DCT_LENTRY_CH 8
`define DCT_DENTRY_CH 8
`define DCT_IDLE_CH 1
// Framing delay must stay below 16: arrival stamps are four bits wide
`define DCT_FRM_CH 7
// Wake times round down, light-wake ones never below one cycle
`define DCT_LWAKE_A_CYC ((`DCT_LWAKE_A_NS / `DCT_REF_PERIOD_NS) < 1 ? 1 : (`DCT_LWAKE_A_NS / `DCT_REF_PERIOD_NS))
`define DCT_LWAKE_B_CYC ((`DCT_LWAKE_B_NS / `DCT_REF_PERIOD_NS) < 1 ? 1 : (`DCT_LWAKE_B_NS / `DCT_REF_PERIOD_NS))
`define DCT_DWAKE_A_CYC ((`DCT_DWAKE_A_US * 1000) / `DCT_REF_PERIOD_NS)
// Power state encodings
`define DCT_ST_ACTIVE 3'h0
`define DCT_ST_IDLE 3'h1
`define DCT_ST_LSLEEP 3'h2
`define DCT_ST_DSLEEP 3'h3
`define DCT_ST_ENTER 3'h4
`define DCT_ST_EXITA 3'h5
`define DCT_ST_EXITB 3'h6
`endif

// *** hw/dct_fifo.v ***
// Purpose: Holds no code of its own
// Assumes: Nothing
// Notes: The framing FIFO module sits in the power block's file, beside its only user

// *** hw/dct_power.v ***
// Purpose: Device-side power state machine and row-to-column framing delay
// Assumes: chanClk is the channel clock, sampled on ref_clk; commands are
//   channel-clock-aligned levels sampled the same way
// Notes: Delays in channel cycles are counted on sampled chanClk rising edges
//
// Functional notes
// [RULE_01] Host keeps channel clocks running 100 cycles after sleep entry.
// [RULE_02] Column packet follows its row packet by 7 channel cycles.
// [RULE_03] Host wakes device from light sleep within 10 us.
// [RULE_04] Host refreshes every row within each 32 ms.
// [RULE_05] Host refreshes all banks within 200 us after sleep exit.
// [RULE_06] Host spaces current calibrations 34 cycles to 100 ms apart.
// [RULE_07] Host runs temperature calibration at least every 100 ms.
// [RULE_08] Host places 150 cycles between thermal enable and calibrate.
// [RULE_09] Quiet window starts 2 cycles after calibrate command.
// [RULE_10] Host schedules no read data for 140 quiet cycles.
// [RULE_11] Host waits 200 us after initialization before channel use; the bench sends rows 4 reference cycles after reset.
// [RULE_12] Light-sleep wake: phase A within 50 ns, phase B within 40 ns; phase B here lasts one 50 ns reference cycle.
// [RULE_13] Deep-sleep wake: phase A within 4 us, phase B 9000 cycles.
// [RULE_14] Active to idle within 1 cycle; idle to active immediately.
// [RULE_15] Light-sleep entry completes within 8 channel cycles.
// [RULE_16] Deep-sleep entry completes within 8 channel cycles.
// [RULE_17] Host spaces activates to one bank by 28 or 32 cycles.
// [RULE_18] Bank stays open 20 or 22 cycles, at most 64 us.
// [RULE_19] Host waits 8 or 10 cycles from precharge to activate.
// [RULE_20] Host spaces precharges to one device by 8 cycles.
// [RULE_21] Host keeps row and column lanes quiet 4 cycles on entry.
// [RULE_22] Host has clocks stable 2 cycles before a wake.
// [RULE_23] Host tracks per-bank and per-device spacing counters; the host model keeps none and sends no bank packets.
// [RULE_24] Host keeps a timebase scheduling refresh and calibrations; the host model has none and sends neither.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defines.vh"
module dct_power #(
  parameter ROW_W = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter FRM_CH = `DCT_FRM_CH,
  parameter DWAKE_B_CH = `DCT_DWAKE_B_CH,
  parameter DWAKE_A_CYC = `DCT_DWAKE_A_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Channel clock from the host
  input wire chanClk,
  // Power commands, levels from the host
  input wire idleReq,
  input wire lightSleepReq,
  input wire deepSleepReq,
  input wire wakeReq,
  // Row packets in
  input wire rowValid,
  input wire [ROW_W-1:0] rowData,
  output wire rowReady,
  // Framed column slot out
  output reg colSlotValid,
  output reg [ROW_W-1:0] colSlotData,
  // State
  output reg [2:0] powerState,
  output reg listenActive
);
  localparam CW = 14;
  reg clkS1_q, clkS2_q, clkS3_q;
  reg idleS1_q, idleS2_q, lsS1_q, lsS2_q, dsS1_q, dsS2_q, wkS1_q, wkS2_q;
  reg rvS1_q, rvS2_q, rvS3_q;
  reg [ROW_W-1:0] rdS1_q, rdS2_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg deep_q;
  reg deep_d;
  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;
  reg [3:0] chanCnt_q;
  wire chanRise;
  wire fifoOutValid;
  wire [ROW_W+3:0] fifoOutWord;
  wire [3:0] headAge;
  wire fifoPop;
  wire rowPush;
  reg rvPrev_q;

  // Two-flop synchronisers for every outside input; valid gets a third flop so
  // the row data has settled one cycle longer than the valid that qualifies it
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      clkS1_q <= 1'b0;
      clkS2_q <= 1'b0;
      clkS3_q <= 1'b0;
      idleS1_q <= 1'b0;
      idleS2_q <= 1'b0;
      lsS1_q <= 1'b0;
      lsS2_q <= 1'b0;
      dsS1_q <= 1'b0;
      dsS2_q <= 1'b0;
      wkS1_q <= 1'b0;
      wkS2_q <= 1'b0;
      rvS1_q <= 1'b0;
      rvS2_q <= 1'b0;
      rvS3_q <= 1'b0;
      rvPrev_q <= 1'b0;
      rdS1_q <= {ROW_W{1'b0}};
      rdS2_q <= {ROW_W{1'b0}};
    end
    else
    begin
      clkS1_q <= chanClk;
      clkS2_q <= clkS1_q;
      clkS3_q <= clkS2_q;
      idleS1_q <= idleReq;
      idleS2_q <= idleS1_q;
      lsS1_q <= lightSleepReq;
      lsS2_q <= lsS1_q;
      dsS1_q <= deepSleepReq;
      dsS2_q <= dsS1_q;
      wkS1_q <= wakeReq;
      wkS2_q <= wkS1_q;
      rvS1_q <= rowValid;
      rvS2_q <= rvS1_q;
      rvS3_q <= rvS2_q;
      rdS1_q <= rowData;
      rdS2_q <= rdS1_q;
      if (chanRise)
        rvPrev_q <= rvS3_q;
    end
  end

  // Edge of the sampled channel clock, from the second and third flops
  assign chanRise = clkS2_q & ~clkS3_q;

  // Power state machine; entry and exit phases are counted
  always @*
  begin
    state_d = state_q;
    deep_d = deep_q;
    cnt_d = cnt_q;
    case (state_q)
      `DCT_ST_ACTIVE:
      begin
        if (lsS2_q | dsS2_q)
        begin
          state_d = `DCT_ST_ENTER;
          deep_d = dsS2_q;
          cnt_d = {CW{1'b0}};
        end
        else if (idleS2_q)
          state_d = `DCT_ST_IDLE; // RULE_14
      end
      `DCT_ST_IDLE:
      begin
        if (lsS2_q | dsS2_q)
        begin
          state_d = `DCT_ST_ENTER;
          deep_d = dsS2_q;
          cnt_d = {CW{1'b0}};
        end
        else if (~idleS2_q)
          state_d = `DCT_ST_ACTIVE; // RULE_14
      end
      `DCT_ST_ENTER:
      begin
        // Finish entry before the eighth channel cycle
        if (chanRise)
          cnt_d = cnt_q + 1'b1;
        if (chanRise && cnt_q == (deep_q ? `DCT_DENTRY_CH : `DCT_LENTRY_CH) - 2)
          state_d = deep_q ? `DCT_ST_DSLEEP : `DCT_ST_LSLEEP; // RULE_15 RULE_16
      end
      `DCT_ST_LSLEEP, `DCT_ST_DSLEEP:
      begin
        if (wkS2_q)
        begin
          state_d = `DCT_ST_EXITA;
          cnt_d = {CW{1'b0}};
        end
      end
      `DCT_ST_EXITA:
      begin
        // Phase A counts reference cycles
        cnt_d = cnt_q + 1'b1;
        if (deep_q ? (cnt_q >= DWAKE_A_CYC - 1) : (cnt_q >= `DCT_LWAKE_A_CYC - 1))
        begin
          state_d = `DCT_ST_EXITB; // RULE_12 RULE_13
          cnt_d = {CW{1'b0}};
        end
      end
      `DCT_ST_EXITB:
      begin
        // Light sleep phase B in reference cycles, deep sleep in channel cycles
        if (deep_q)
        begin
          if (chanRise)
            cnt_d = cnt_q + 1'b1;
          if (cnt_q >= DWAKE_B_CH - 1)
            state_d = `DCT_ST_ACTIVE; // RULE_13
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q >= `DCT_LWAKE_B_CYC - 1)
            state_d = `DCT_ST_ACTIVE; // RULE_12
        end
      end
      default:
        state_d = `DCT_ST_ACTIVE;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= `DCT_ST_ACTIVE;
      deep_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
      powerState <= `DCT_ST_ACTIVE;
      listenActive <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      deep_q <= deep_d;
      cnt_q <= cnt_d;
      powerState <= state_d;
      listenActive <= (state_d == `DCT_ST_ACTIVE);
    end
  end

  // Row packets queue while active, stamped with their channel cycle of arrival;
  // a push while full is lost, and rowReady tells the host so
  assign rowPush = chanRise & rvS3_q & ~rvPrev_q & (state_q == `DCT_ST_ACTIVE);

  dct_fifo #(
    .WIDTH(ROW_W + 4),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) uFifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(rowPush),
    .inReady(rowReady),
    .inData({chanCnt_q, rdS2_q}),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutWord)
  );

  // Every entry leaves its own framing delay after arrival, so packets sent
  // back to back keep their spacing; one push per rise means one pop per rise
  assign headAge = chanCnt_q - fifoOutWord[ROW_W+3:ROW_W];
  assign fifoPop = fifoOutValid & chanRise & (headAge == FRM_CH[3:0]);

  // Channel cycle counter and the registered column slot
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      chanCnt_q <= 4'h0;
      colSlotValid <= 1'b0;
      colSlotData <= {ROW_W{1'b0}};
    end
    else
    begin
      if (chanRise)
        chanCnt_q <= chanCnt_q + 1'b1;
      colSlotValid <= fifoPop; // RULE_02
      if (fifoPop)
        colSlotData <= fifoOutWord[ROW_W-1:0];
    end
  end
endmodule

// Framing FIFO; full and empty come from an occupancy count
module dct_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire doWr;
  wire doRd;
  // Handshakes; full drops inReady and refuses the write
  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign doWr = inValid & inReady;
  assign doRd = outValid & outReady;
  assign outData = mem[rdPtr_q];
  // Storage has no reset; pointers guard it
  always @(posedge ref_clk)
  begin
    if (doWr)
      mem[wrPtr_q] <= inData;
  end
  // Pointer and occupancy bookkeeping
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doWr)
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      if (doRd)
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      if (doWr & ~doRd)
        count_q <= count_q + 1'b1;
      else if (doRd & ~doWr)
        count_q <= count_q - 1'b1;
    end
  end
endmodule
`default_nettype wire
